// [arb_bank.sv]
// arb_bank: channel-disable register and current result registers
// assumes a byte register port on clk_sys; converter results arrive on the same clock
// Operation
// - disable register, reset zero, bit-per-channel
// - bit one reserved, reads zero
// - bus current signed sixteen bits, hi/lo
// - bus current weights 1mA to 16384mA
// - current into pin reads positive
// - charge high byte, bit seven zero
// - charge high byte weights 256mA upward
// - results read-only, soft reset clears, watchdog not
// - charge low byte holds bits seven..zero
// - updates only while converter enabled
`timescale 1ns/1ps
`default_nettype none
module arb_bank (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        ce,
    // resets from elsewhere
    input  wire logic        reg_reset,
    input  wire logic        watchdog_expired,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    output logic             reg_hit,
    // converter
    input  wire logic        conv_on,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_value,
    output arb_pkg::arb_chan_t conv_chan,
    output logic [7:0]       chan_off_bits
);
    logic [7:0]  disable_q;
    logic [15:0] bus_current_result_q;
    logic [14:0] charge_current_result_q;
    logic [7:0]  ibus_lo_shadow_q;
    logic [7:0]  ichg_lo_shadow_q;
    logic        reg_hit_d;
    logic [7:0]  reg_rdata_d;

    arb_seq u_seq (
        .clk_sys      (clk_sys),
        .rstn         (rstn),
        .ce           (ce),
        .soft_clr     (reg_reset),
        .conv_on      (conv_on),
        .disable_bits (disable_q),
        .conv_done    (conv_done),
        .chan_q       (conv_chan)
    );

    assign chan_off_bits = disable_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            disable_q <= arb_pkg::RST_DISABLE;
        end else if (ce) begin
            // register-reset command frozen with the rest while ce is low
            if (reg_reset) begin
                disable_q <= arb_pkg::RST_DISABLE;
            end else if (reg_wr && reg_addr == arb_pkg::OFF_DISABLE) begin
                disable_q <= reg_wdata & arb_pkg::DISABLE_MASK;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            bus_current_result_q <= {arb_pkg::RST_RESULT, arb_pkg::RST_RESULT};
        end else if (ce) begin
            if (reg_reset) begin
                bus_current_result_q <= {arb_pkg::RST_RESULT, arb_pkg::RST_RESULT};
            end else if (conv_on && conv_done && conv_chan == arb_pkg::ARB_CH_IBUS
                         && !disable_q[arb_pkg::BIT_IBUS]) begin
                bus_current_result_q <= conv_value;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            charge_current_result_q <= {arb_pkg::RST_RESULT[6:0], arb_pkg::RST_RESULT};
        end else if (ce) begin
            if (reg_reset) begin
                charge_current_result_q <= {arb_pkg::RST_RESULT[6:0], arb_pkg::RST_RESULT};
            end else if (conv_on && conv_done && conv_chan == arb_pkg::ARB_CH_ICHG
                         && !disable_q[arb_pkg::BIT_ICHG]) begin
                charge_current_result_q <= conv_value[14:0];
            end
        end
    end

    // low byte frozen at high read
    // high read latches the low half so a following low read matches it
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ibus_lo_shadow_q <= arb_pkg::RST_RESULT;
            ichg_lo_shadow_q <= arb_pkg::RST_RESULT;
        end else if (ce) begin
            if (reg_reset) begin
                ibus_lo_shadow_q <= arb_pkg::RST_RESULT;
                ichg_lo_shadow_q <= arb_pkg::RST_RESULT;
            end else if (reg_rd) begin
                if (reg_addr == arb_pkg::OFF_IBUS_HI) begin
                    ibus_lo_shadow_q <= bus_current_result_q[7:0];
                end
                if (reg_addr == arb_pkg::OFF_ICHG_HI) begin
                    ichg_lo_shadow_q <= charge_current_result_q[7:0];
                end
            end
        end
    end

    always_comb begin
        reg_hit_d   = 1'b1;
        reg_rdata_d = 8'h00;
        case (reg_addr)
            arb_pkg::OFF_DISABLE: reg_rdata_d = disable_q & arb_pkg::DISABLE_MASK;
            arb_pkg::OFF_IBUS_HI: reg_rdata_d = bus_current_result_q[15:8];
            arb_pkg::OFF_IBUS_LO: reg_rdata_d = ibus_lo_shadow_q;
            arb_pkg::OFF_ICHG_HI: reg_rdata_d = {1'b0, charge_current_result_q[14:8]};
            arb_pkg::OFF_ICHG_LO: reg_rdata_d = ichg_lo_shadow_q;
            default:              reg_hit_d   = 1'b0;
        endcase
    end

    // data registered; unmapped reads return zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
            reg_hit   <= 1'b0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? reg_rdata_d : 8'h00;
            reg_hit   <= reg_rd & reg_hit_d;
        end
    end

    // watchdog expiry deliberately has no effect on this bank
    logic unused_wd;
    assign unused_wd = watchdog_expired;

    property p_rsvd_zero;
        @(posedge clk_sys) disable iff (!rstn)
            (disable_q & ~arb_pkg::DISABLE_MASK) == 8'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved disable bit set");

    property p_disable_wr;
        @(posedge clk_sys) disable iff (!rstn)
            ce && reg_wr && reg_addr == arb_pkg::OFF_DISABLE && !reg_reset
            |=> disable_q == ($past(reg_wdata) & arb_pkg::DISABLE_MASK);
    endproperty
    a_disable_wr: assert property (p_disable_wr) else $error("disable write not stored");

    property p_soft_clr;
        @(posedge clk_sys) disable iff (!rstn)
            ce && reg_reset
            |=> disable_q == arb_pkg::RST_DISABLE
                && bus_current_result_q == {arb_pkg::RST_RESULT, arb_pkg::RST_RESULT}
                && charge_current_result_q == {arb_pkg::RST_RESULT[6:0], arb_pkg::RST_RESULT}
                && conv_chan == arb_pkg::ARB_CH_IBUS;
    endproperty
    a_soft_clr: assert property (p_soft_clr) else $error("soft reset not clearing");

    property p_hold_off;
        @(posedge clk_sys) disable iff (!rstn)
            !conv_on && !reg_reset
            |=> $stable(bus_current_result_q) && $stable(charge_current_result_q);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("result changed while off");

    property p_ichg_top;
        @(posedge clk_sys) disable iff (!rstn)
            ce && reg_rd && reg_addr == arb_pkg::OFF_ICHG_HI
            |=> reg_rdata[7] == 1'b0;
    endproperty
    a_ichg_top: assert property (p_ichg_top) else $error("charge high bit7 set");

    property p_wd_keep;
        @(posedge clk_sys) disable iff (!rstn)
            watchdog_expired && !reg_reset
            |=> $stable(disable_q) || $past(reg_wr);
    endproperty
    a_wd_keep: assert property (p_wd_keep) else $error("watchdog altered state");

    property p_skip;
        @(posedge clk_sys) disable iff (!rstn)
            disable_q[arb_pkg::BIT_ICHG] && !reg_reset
            |=> $stable(charge_current_result_q);
    endproperty
    a_skip: assert property (p_skip) else $error("disabled channel updated");

    property p_hi_read;
        @(posedge clk_sys) disable iff (!rstn)
            ce && reg_rd && reg_addr == arb_pkg::OFF_IBUS_HI && !reg_reset
            |=> reg_rdata == $past(bus_current_result_q[15:8])
                && ibus_lo_shadow_q == $past(bus_current_result_q[7:0]);
    endproperty
    a_hi_read: assert property (p_hi_read) else $error("high read pair mismatch");

    property p_ichg_pair;
        @(posedge clk_sys) disable iff (!rstn)
            ce && reg_rd && reg_addr == arb_pkg::OFF_ICHG_HI && !reg_reset
            |=> ichg_lo_shadow_q == $past(charge_current_result_q[7:0]);
    endproperty
    a_ichg_pair: assert property (p_ichg_pair) else $error("charge pair mismatch");

    property p_capture;
        @(posedge clk_sys) disable iff (!rstn)
            ce && conv_on && conv_done && conv_chan == arb_pkg::ARB_CH_IBUS
            && !disable_q[arb_pkg::BIT_IBUS] && !reg_reset
            |=> bus_current_result_q == $past(conv_value);
    endproperty
    a_capture: assert property (p_capture) else $error("bus current not captured");
endmodule
`default_nettype wire

// [arb_pkg.sv]
// arb_pkg: offsets, field positions, reset values for the monitor result bank
// assumes byte-wide register port with 8-bit addresses
package arb_pkg;
    localparam logic [7:0] OFF_CTRL      = 8'h15;
    localparam logic [7:0] OFF_DISABLE   = 8'h16;
    localparam logic [7:0] OFF_IBUS_HI   = 8'h17;
    localparam logic [7:0] OFF_IBUS_LO   = 8'h18;
    localparam logic [7:0] OFF_ICHG_HI   = 8'h19;
    localparam logic [7:0] OFF_ICHG_LO   = 8'h1a;
    localparam logic [7:0] RST_DISABLE   = 8'h00;
    localparam logic [7:0] RST_RESULT    = 8'h00;
    localparam logic [7:0] DISABLE_MASK  = 8'hfd;
    localparam int         CONV_EN_BIT   = 7;
    localparam int         BIT_IBUS      = 7;
    localparam int         BIT_ICHG      = 6;
    localparam int         BIT_INPUT_BUS_PIN      = 5;
    localparam int         BIT_VBAT      = 4;
    localparam int         BIT_VSYS      = 3;
    localparam int         BIT_TS        = 2;
    localparam int         BIT_TDIE      = 0;
    localparam int         IBUS_W        = 16;
    localparam int         ICHG_W        = 15;
    typedef enum logic [2:0] {
        ARB_CH_IBUS, ARB_CH_ICHG, ARB_CH_INPUT_BUS_PIN, ARB_CH_VBAT,
        ARB_CH_VSYS, ARB_CH_TS, ARB_CH_TDIE
    } arb_chan_t;
endpackage

// [arb_seq.sv]
// arb_seq: round-robin conversion sequencer over the seven channels
// assumes converter reports done one cycle per conversion
`timescale 1ns/1ps
`default_nettype none
module arb_seq (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic              ce,
    input  wire logic              soft_clr,
    // control
    input  wire logic              conv_on,
    input  wire logic [7:0]        disable_bits,
    input  wire logic              conv_done,
    // selection
    output arb_pkg::arb_chan_t     chan_q
);
    function automatic logic chan_off(input arb_pkg::arb_chan_t c, input logic [7:0] d);
        case (c)
            arb_pkg::ARB_CH_IBUS: chan_off = d[arb_pkg::BIT_IBUS];
            arb_pkg::ARB_CH_ICHG: chan_off = d[arb_pkg::BIT_ICHG];
            arb_pkg::ARB_CH_INPUT_BUS_PIN: chan_off = d[arb_pkg::BIT_INPUT_BUS_PIN];
            arb_pkg::ARB_CH_VBAT: chan_off = d[arb_pkg::BIT_VBAT];
            arb_pkg::ARB_CH_VSYS: chan_off = d[arb_pkg::BIT_VSYS];
            arb_pkg::ARB_CH_TS:   chan_off = d[arb_pkg::BIT_TS];
            default:              chan_off = d[arb_pkg::BIT_TDIE];
        endcase
    endfunction

    function automatic arb_pkg::arb_chan_t chan_next(input arb_pkg::arb_chan_t c);
        case (c)
            arb_pkg::ARB_CH_IBUS: chan_next = arb_pkg::ARB_CH_ICHG;
            arb_pkg::ARB_CH_ICHG: chan_next = arb_pkg::ARB_CH_INPUT_BUS_PIN;
            arb_pkg::ARB_CH_INPUT_BUS_PIN: chan_next = arb_pkg::ARB_CH_VBAT;
            arb_pkg::ARB_CH_VBAT: chan_next = arb_pkg::ARB_CH_VSYS;
            arb_pkg::ARB_CH_VSYS: chan_next = arb_pkg::ARB_CH_TS;
            arb_pkg::ARB_CH_TS:   chan_next = arb_pkg::ARB_CH_TDIE;
            default:              chan_next = arb_pkg::ARB_CH_IBUS;
        endcase
    endfunction

    arb_pkg::arb_chan_t step_d;

    always_comb begin
        step_d = chan_q;
        if (conv_done || chan_off(chan_q, disable_bits)) begin
            step_d = chan_next(chan_q);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            chan_q <= arb_pkg::ARB_CH_IBUS;
        end else if (ce) begin
            // register-reset command obeys the clock enable like any write
            if (soft_clr) begin
                chan_q <= arb_pkg::ARB_CH_IBUS;
            end else if (conv_on) begin
                chan_q <= step_d;
            end
        end
    end
endmodule
`default_nettype wire

// [arb_conv_model.sv]
// arb_conv_model: converter stand-in, one result per sequencer slot
// assumes conv_chan from arb_bank on clk_sys; fast or every-other-cycle answers
`timescale 1ns/1ps
`default_nettype none
module arb_conv_model (
    // clock
    input  wire logic               clk_sys,
    // control from bench
    input  wire logic               go,
    input  wire logic               slow,
    input  wire logic [15:0]        ibus,
    input  wire logic [15:0]        ichg,
    // converter side
    input  wire arb_pkg::arb_chan_t chan,
    output logic                    conv_done,
    output logic [15:0]             conv_value
);
    logic ph_q = 1'b0;
    always @(posedge clk_sys) begin
        ph_q <= ~ph_q;
    end
    assign conv_done = go & (~slow | ph_q);
    // other channels see a moving pattern, never a stale copy
    assign conv_value = (chan == arb_pkg::ARB_CH_IBUS) ? ibus :
                        (chan == arb_pkg::ARB_CH_ICHG) ? ichg : {8'h00, ph_q, 7'h55};
endmodule
`default_nettype wire

// [arb_bank_tb_top.sv]
// arb_bank_tb_top: register reads scored against a queue of expected bytes
// assumes arb_bank and arb_conv_model compiled first
`timescale 1ns/1ps
`default_nettype none
module arb_bank_tb_top;
    logic clk_sys, rstn, ce, rst_cmd, wdog, wr, rd, go, slow, hit, done;
    bit rd_seen;
    logic [7:0] addr, wdata, rdata, offs;
    logic [15:0] ibus, ichg, cval, eb, ec;
    logic [8:0] expq[$];
    arb_pkg::arb_chan_t chan;
    int err_total, checks, seed;
    arb_bank arb_bank_inst (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .reg_reset(rst_cmd),
        .watchdog_expired(wdog), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
        .reg_rdata(rdata), .reg_hit(hit), .conv_on(go), .conv_done(done), .conv_value(cval),
        .conv_chan(chan), .chan_off_bits(offs));
    arb_conv_model arb_conv_model_inst (.clk_sys(clk_sys), .go(go), .slow(slow), .ibus(ibus),
        .ichg(ichg), .chan(chan), .conv_done(done), .conv_value(cval));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    function automatic int xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic cmp9(input string n, input logic [8:0] e, input logic [8:0] s);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    // last clear keeps strobe up across back-to-back reads
    task automatic rd_reg(input logic [7:0] a, input logic [8:0] e, input logic last);
        expq.push_back(e);
        addr = a;
        if (!rd) rd = 1'b1;
        tick(1);
        // a closing read lets one edge pass so the next strobe is a fresh one
        if (last) begin
            rd = 1'b0;
            tick(1);
        end
    endtask
    always @(posedge clk_sys) begin
        if (rd_seen) cmp9("rdata", expq.pop_front(), {hit, rdata});
        rd_seen <= rd && rstn;
    end
    task automatic print_verdict();
        tick(2);
        if (expq.size() != 0) err_total++;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #2_000_000;
        err_total++;
        print_verdict();
    end
    initial begin
        seed = 17030;
        {err_total, checks} = '0;
        {rstn, rst_cmd, wdog, wr, rd, go, slow} = '0;
        ce = 1'b1;
        {addr, wdata, ibus, ichg, eb, ec} = '0;
        repeat (16) @(posedge clk_sys);
        #1 rstn = 1'b1;
        tick(1);
        for (int a = 8'h16; a <= 8'h1a; a++) rd_reg(8'(a), 9'h100, 1);
        rd_reg(8'h20, 9'h000, 1);
        $display("test reset values done");
        wr_reg(arb_pkg::OFF_DISABLE, 8'hff);
        cmp9("offs", 9'h0fd, {1'b0, offs});
        for (int a = 8'h17; a <= 8'h1a; a++) wr_reg(8'(a), 8'(xs()));
        rd_reg(arb_pkg::OFF_DISABLE, 9'h1fd, 0);
        rd_reg(8'h17, 9'h100, 1);
        $display("test access kinds done");
        // third pass masks both currents: their bytes must hold
        for (int k = 0; k < 3; k++) begin
            wr_reg(arb_pkg::OFF_DISABLE, (k == 2) ? 8'hc0 : 8'h00);
            slow = k[0];
            ibus = {k[0], 15'(xs())};
            ichg = 16'(xs());
            if (k < 2) eb = ibus;
            if (k < 2) ec = ichg;
            go = 1'b1;
            tick(30);
            go = 1'b0;
            tick(2);
            rd_reg(8'h17, {1'b1, eb[15:8]}, 0);
            rd_reg(8'h18, {1'b1, eb[7:0]}, 1);
            rd_reg(8'h19, {2'b10, ec[14:8]}, 0);
            rd_reg(8'h1a, {1'b1, ec[7:0]}, 1);
        end
        $display("test conversions done");
        wr_reg(arb_pkg::OFF_DISABLE, 8'h00);
        ibus = ~eb;
        tick(20);
        rd_reg(8'h17, {1'b1, eb[15:8]}, 1);
        // clock enable low: converter answers, bank must not move
        ce = 1'b0;
        go = 1'b1;
        tick(10);
        {ce, go} = 2'b10;
        rd_reg(8'h17, {1'b1, eb[15:8]}, 1);
        go = 1'b1;
        tick(20);
        go = 1'b0;
        tick(2);
        rd_reg(8'h18, {1'b1, eb[7:0]}, 1);
        rd_reg(8'h17, {1'b1, ~eb[15:8]}, 0);
        rd_reg(8'h18, {1'b1, ~eb[7:0]}, 1);
        $display("test hold and pairing done");
        wdog = 1'b1;
        tick(1);
        wdog = 1'b0;
        rd_reg(8'h17, {1'b1, ~eb[15:8]}, 1);
        wr_reg(arb_pkg::OFF_DISABLE, 8'h5c);
        cmp9("offs", 9'h05c, {1'b0, offs});
        rst_cmd = 1'b1;
        tick(1);
        rst_cmd = 1'b0;
        cmp9("offs", 9'h000, {1'b0, offs});
        cmp9("chan", 9'(arb_pkg::ARB_CH_IBUS), 9'(chan));
        for (int a = 8'h16; a <= 8'h1a; a++) rd_reg(8'(a), 9'h100, 1);
        $display("test resets done");
        print_verdict();
    end
endmodule
`default_nettype wire
